// >>> app_port_pkg.sv
`default_nettype none
package app_port_pkg;
	localparam int PAYLOAD_BYTES     = 32;
	localparam logic [7:0] PAYLOAD_LEN_FULL = 8'h20;
	localparam logic [31:0] OFS_CTRL   = 32'h0000_0000;
	localparam logic [31:0] OFS_STATUS = 32'h0000_0004;
	localparam logic [31:0] OFS_TX_CNT = 32'h0000_0008;
	localparam logic [31:0] OFS_RX_CNT = 32'h0000_000C;
	localparam int CTRL_ROUTE_BIT   = 0;
	localparam int STAT_ROUTE_BIT   = 0;
	localparam int STAT_PEND_BIT    = 1;
	localparam int STAT_RXVAL_BIT   = 2;
	localparam logic CTRL_RESET     = 1'b0;
	localparam logic [7:0] SENDER_ID_MAX = 8'hFF;
	localparam int ACCESS_WAIT_CYCLES = 1;
endpackage : app_port_pkg
`default_nettype wire

// >>> apb_regs.sv
`timescale 1ns/1ns
`default_nettype none
module apb_regs
	import app_port_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             route_sel,
	input  wire logic [31:0] status_word,
	input  wire logic [31:0] tx_count,
	input  wire logic [31:0] rx_count
);
	logic        route_ff;
	logic [31:0] prdata_ff;
	logic        err_ff;
	logic        wait_ff;
	logic        hit;
	logic [31:0] nxt_rdata;

	always_comb begin
		hit = 1'b1;
		nxt_rdata = 32'h0000_0000;
		unique case (paddr)
			OFS_CTRL:   nxt_rdata[CTRL_ROUTE_BIT] = route_ff;
			OFS_STATUS: nxt_rdata = status_word;
			OFS_TX_CNT: nxt_rdata = tx_count;
			OFS_RX_CNT: nxt_rdata = rx_count;
			default:    hit = 1'b0;
		endcase
	end

	// One wait state: answer is registered, so pready rises on the second access cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			wait_ff <= 1'b0;
		end else begin
			wait_ff <= psel && penable && !wait_ff;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			route_ff  <= CTRL_RESET;
			prdata_ff <= 32'h0000_0000;
			err_ff    <= 1'b0;
		end else if (psel && penable && !wait_ff) begin
			err_ff    <= !hit;
			prdata_ff <= pwrite ? 32'h0000_0000 : nxt_rdata;
		end else if (psel && penable && pwrite && paddr == OFS_CTRL) begin
			// Write lands only on the edge that completes the transfer
			route_ff <= pwdata[CTRL_ROUTE_BIT];
		end
	end

	assign pready    = wait_ff;
	assign pslverr   = wait_ff && err_ff;
	assign prdata    = prdata_ff;
	assign route_sel = route_ff;

	route_write_a: assert property (@(posedge clk) disable iff (rst)
		psel && penable && pwrite && wait_ff && paddr == OFS_CTRL
		|=> route_sel == $past(pwdata[CTRL_ROUTE_BIT]))
		else $error("route select did not follow control write");
endmodule : apb_regs
`default_nettype wire

// >>> app_data_port.sv
`timescale 1ns/1ns
`default_nettype none
module app_data_port
	import app_port_pkg::*;
#(
	parameter int NBYTES = PAYLOAD_BYTES
)(
	input  wire logic               MCLK,
	input  wire logic               RST,
	input  wire logic               PSEL,
	input  wire logic               PENABLE,
	input  wire logic               PWRITE,
	input  wire logic [31:0]        PADDR,
	input  wire logic [31:0]        PWDATA,
	output logic [31:0]             PRDATA,
	output logic                    PREADY,
	output logic                    PSLVERR,
	// Application source side
	input  wire logic [7:0]         SRC_APPLICATION_SELECTOR,
	input  wire logic [NBYTES*8-1:0] SRC_PAYLOAD_BYTES,
	input  wire logic [7:0]         SRC_PAYLOAD_LENGTH,
	input  wire logic               SRC_PAYLOAD_VALID,
	input  wire logic [15:0]        SRC_UPDATE_SEQUENCE,
	input  wire logic [63:0]        SRC_UPDATE_TIME_TAI,
	// Frame transmitter side: serial byte stream out
	output logic                    TX_START,
	output logic                    TX_BYTE_VALID,
	output logic [7:0]              TX_BYTE,
	input  wire logic               TX_BYTE_READY,
	output logic [7:0]              TX_APPLICATION_SELECTOR,
	output logic [15:0]             TX_UPDATE_SEQUENCE,
	output logic [63:0]             TX_UPDATE_TIME_TAI,
	// Frame receiver side: parsed byte stream in
	input  wire logic               RX_START,
	input  wire logic               RX_BYTE_VALID,
	input  wire logic [7:0]         RX_BYTE,
	input  wire logic               RX_END,
	input  wire logic [7:0]         RX_APPLICATION_SELECTOR,
	input  wire logic [15:0]        RX_UPDATE_SEQUENCE,
	input  wire logic [63:0]        RX_UPDATE_TIME_TAI,
	input  wire logic [15:0]        RX_SENDER_NODE_ID,
	// Application sink side
	output logic [7:0]              SNK_APPLICATION_SELECTOR,
	output logic [NBYTES*8-1:0]     SNK_PAYLOAD_BYTES,
	output logic [7:0]              SNK_PAYLOAD_LENGTH,
	output logic                    SNK_PAYLOAD_VALID,
	output logic [15:0]             SNK_UPDATE_SEQUENCE,
	output logic [63:0]             SNK_UPDATE_TIME_TAI,
	output logic [15:0]             SNK_SENDER_NODE_ID
);
	if (NBYTES < 1 || NBYTES > 255) begin : g_nbytes_check
		$error("NBYTES out of range");
	end

	localparam logic [7:0] LAST_IDX = 8'(NBYTES - 1);

	typedef enum logic [1:0] {TX_IDLE, TX_SEND} tx_state_t;

	logic                   route_sel;
	logic [31:0]            tx_cnt_ff;
	logic [31:0]            rx_cnt_ff;
	tx_state_t              tx_st_ff;
	logic [NBYTES*8-1:0]    tx_buf_ff;
	logic [7:0]             tx_idx_ff;
	logic [7:0]             tx_sel_ff;
	logic [15:0]            tx_seq_ff;
	logic [63:0]            tx_tai_ff;
	logic                   tx_start_ff;
	logic [NBYTES*8-1:0]    rx_buf_ff;
	logic [7:0]             rx_cnt_bytes_ff;
	logic                   rx_act_ff;
	logic [NBYTES*8-1:0]    nxt_rx_buf;
	logic [7:0]             nxt_rx_cnt_bytes;
	logic [7:0]             snk_sel_ff;
	logic [NBYTES*8-1:0]    snk_data_ff;
	logic [7:0]             snk_len_ff;
	logic                   snk_val_ff;
	logic [15:0]            snk_seq_ff;
	logic [63:0]            snk_tai_ff;
	logic [15:0]            snk_id_ff;
	logic                   take_src;
	logic                   tx_step;
	logic [31:0]            status_word;

	////////////////////////////////////////////////////////////////////////////////
	apb_regs u_regs (
		.clk         (MCLK),
		.rst         (RST),
		.psel        (PSEL),
		.penable     (PENABLE),
		.pwrite      (PWRITE),
		.paddr       (PADDR),
		.pwdata      (PWDATA),
		.prdata      (PRDATA),
		.pready      (PREADY),
		.pslverr     (PSLVERR),
		.route_sel   (route_sel),
		.status_word (status_word),
		.tx_count    (tx_cnt_ff),
		.rx_count    (rx_cnt_ff)
	);

	always_comb begin
		status_word = 32'h0000_0000;
		status_word[STAT_ROUTE_BIT] = route_sel;
		status_word[STAT_PEND_BIT]  = (tx_st_ff == TX_SEND);
		status_word[STAT_RXVAL_BIT] = snk_val_ff;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Records arriving while a frame is still going out are dropped, not queued
	assign take_src = route_sel && SRC_PAYLOAD_VALID && (tx_st_ff == TX_IDLE);
	assign tx_step  = (tx_st_ff == TX_SEND) && TX_BYTE_READY;

	always_ff @(posedge MCLK) begin
		if (RST) begin
			tx_st_ff  <= TX_IDLE;
			tx_idx_ff <= 8'h00;
		end else begin
			unique case (tx_st_ff)
				TX_IDLE: begin
					tx_idx_ff <= 8'h00;
					if (take_src) begin
						tx_st_ff <= TX_SEND;
					end
				end
				TX_SEND: begin
					// Fixed count, length input deliberately unused
					if (tx_step) begin
						if (tx_idx_ff == LAST_IDX) begin
							tx_st_ff <= TX_IDLE;
						end
						tx_idx_ff <= tx_idx_ff + 8'h01;
					end
				end
			endcase
		end
	end

	always_ff @(posedge MCLK) begin
		if (RST) begin
			tx_buf_ff   <= '0;
			tx_sel_ff   <= 8'h00;
			tx_seq_ff   <= 16'h0000;
			tx_tai_ff   <= 64'h0000_0000_0000_0000;
			tx_start_ff <= 1'b0;
		end else begin
			tx_start_ff <= take_src;
			if (take_src) begin
				tx_buf_ff <= SRC_PAYLOAD_BYTES;
				tx_sel_ff <= SRC_APPLICATION_SELECTOR;
				tx_seq_ff <= SRC_UPDATE_SEQUENCE;
				tx_tai_ff <= SRC_UPDATE_TIME_TAI;
			end else if (tx_step) begin
				tx_buf_ff <= tx_buf_ff >> 8;
			end
		end
	end

	always_ff @(posedge MCLK) begin
		if (RST) begin
			tx_cnt_ff <= 32'h0000_0000;
		end else if (take_src) begin
			tx_cnt_ff <= tx_cnt_ff + 32'h0000_0001;
		end
	end

	assign TX_START                = tx_start_ff;
	assign TX_BYTE_VALID           = (tx_st_ff == TX_SEND);
	assign TX_BYTE                 = tx_buf_ff[7:0];
	assign TX_APPLICATION_SELECTOR = tx_sel_ff;
	assign TX_UPDATE_SEQUENCE      = tx_seq_ff;
	assign TX_UPDATE_TIME_TAI      = tx_tai_ff;

	capture_hold_a: assert property (@(posedge MCLK) disable iff (RST)
		take_src |=> tx_seq_ff == $past(SRC_UPDATE_SEQUENCE)
			&& tx_sel_ff == $past(SRC_APPLICATION_SELECTOR))
		else $error("source record not captured on valid");
	first_byte_a: assert property (@(posedge MCLK) disable iff (RST)
		take_src |=> TX_BYTE == $past(SRC_PAYLOAD_BYTES[7:0]))
		else $error("byte 0 not sent first");
	fixed_count_a: assert property (@(posedge MCLK) disable iff (RST)
		tx_step && tx_idx_ff == LAST_IDX |=> tx_st_ff == TX_IDLE)
		else $error("frame did not end after last byte");
	route_gate_a: assert property (@(posedge MCLK) disable iff (RST)
		!route_sel && tx_st_ff == TX_IDLE |=> tx_st_ff == TX_IDLE)
		else $error("send started with external route off");

	////////////////////////////////////////////////////////////////////////////////
	// Bytes beyond the array are counted but not stored
	// The last byte may ride with the end strobe, so the record takes the next value
	always_comb begin
		nxt_rx_buf       = rx_buf_ff;
		nxt_rx_cnt_bytes = rx_cnt_bytes_ff;
		if (rx_act_ff && RX_BYTE_VALID && rx_cnt_bytes_ff != 8'hFF) begin
			if (rx_cnt_bytes_ff < 8'(NBYTES)) begin
				nxt_rx_buf[rx_cnt_bytes_ff*8 +: 8] = RX_BYTE;
			end
			nxt_rx_cnt_bytes = rx_cnt_bytes_ff + 8'h01;
		end
	end

	always_ff @(posedge MCLK) begin
		if (RST) begin
			rx_buf_ff       <= '0;
			rx_cnt_bytes_ff <= 8'h00;
			rx_act_ff       <= 1'b0;
		end else if (RX_START) begin
			rx_buf_ff       <= '0;
			rx_cnt_bytes_ff <= 8'h00;
			rx_act_ff       <= route_sel;
		end else if (rx_act_ff) begin
			rx_buf_ff       <= nxt_rx_buf;
			rx_cnt_bytes_ff <= nxt_rx_cnt_bytes;
			if (RX_END) begin
				rx_act_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge MCLK) begin
		if (RST) begin
			snk_sel_ff  <= 8'h00;
			snk_data_ff <= '0;
			snk_len_ff  <= 8'h00;
			snk_val_ff  <= 1'b0;
			snk_seq_ff  <= 16'h0000;
			snk_tai_ff  <= 64'h0000_0000_0000_0000;
			snk_id_ff   <= 16'h0000;
			rx_cnt_ff   <= 32'h0000_0000;
		end else begin
			snk_val_ff <= 1'b0;
			if (rx_act_ff && RX_END && RX_SENDER_NODE_ID <= {8'h00, SENDER_ID_MAX}) begin
				snk_val_ff  <= 1'b1;
				snk_sel_ff  <= RX_APPLICATION_SELECTOR;
				snk_data_ff <= nxt_rx_buf;
				snk_len_ff  <= nxt_rx_cnt_bytes;
				snk_seq_ff  <= RX_UPDATE_SEQUENCE;
				snk_tai_ff  <= RX_UPDATE_TIME_TAI;
				snk_id_ff   <= RX_SENDER_NODE_ID;
				rx_cnt_ff   <= rx_cnt_ff + 32'h0000_0001;
			end
		end
	end

	assign SNK_APPLICATION_SELECTOR = snk_sel_ff;
	assign SNK_PAYLOAD_BYTES        = snk_data_ff;
	assign SNK_PAYLOAD_LENGTH       = snk_len_ff;
	assign SNK_PAYLOAD_VALID        = snk_val_ff;
	assign SNK_UPDATE_SEQUENCE      = snk_seq_ff;
	assign SNK_UPDATE_TIME_TAI      = snk_tai_ff;
	assign SNK_SENDER_NODE_ID       = snk_id_ff;

	seq_pass_a: assert property (@(posedge MCLK) disable iff (RST)
		SNK_PAYLOAD_VALID |-> SNK_UPDATE_SEQUENCE == $past(RX_UPDATE_SEQUENCE)
			&& SNK_UPDATE_TIME_TAI == $past(RX_UPDATE_TIME_TAI))
		else $error("sequence or time not passed through");
	len_count_a: assert property (@(posedge MCLK) disable iff (RST)
		SNK_PAYLOAD_VALID |-> SNK_PAYLOAD_LENGTH == rx_cnt_bytes_ff)
		else $error("length differs from received count");
	id_range_a: assert property (@(posedge MCLK) disable iff (RST)
		SNK_PAYLOAD_VALID |-> SNK_SENDER_NODE_ID[15:8] == 8'h00)
		else $error("sender id beyond supported range");
	valid_pulse_a: assert property (@(posedge MCLK) disable iff (RST)
		SNK_PAYLOAD_VALID |-> $past(rx_act_ff) && $past(RX_END))
		else $error("sink valid without frame end");
endmodule : app_data_port
`default_nettype wire

// >>> far_side_model.sv
`timescale 1ns/1ns
`default_nettype none
module far_side_model (
	input  wire logic        MCLK,
	input  wire logic        TX_BYTE_VALID,
	input  wire logic [7:0]  TX_BYTE,
	output logic             TX_BYTE_READY,
	output logic             RX_START,
	output logic             RX_BYTE_VALID,
	output logic [7:0]       RX_BYTE,
	output logic             RX_END,
	output logic [7:0]       RX_APPLICATION_SELECTOR,
	output logic [15:0]      RX_UPDATE_SEQUENCE,
	output logic [63:0]      RX_UPDATE_TIME_TAI,
	output logic [15:0]      RX_SENDER_NODE_ID
);
	logic [7:0] got[$];
	logic       stall = 1'b0;

	initial begin
		{TX_BYTE_READY, RX_START, RX_BYTE_VALID, RX_END} = 4'h0;
		{RX_BYTE, RX_APPLICATION_SELECTOR, RX_UPDATE_SEQUENCE} = 32'h0;
		{RX_UPDATE_TIME_TAI, RX_SENDER_NODE_ID} = 80'h0;
	end

	// Slow mode takes a byte only every other cycle
	always @(posedge MCLK) begin
		if (TX_BYTE_VALID === 1'b1 && TX_BYTE_READY === 1'b1)
			got.push_back(TX_BYTE);
		TX_BYTE_READY <= stall ? ~TX_BYTE_READY : 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////
	// Record fields are only meaningful at the end strobe, so they are garbled elsewhere
	task automatic send_frame(input int n, input logic [7:0] base, input logic [7:0] sel,
		input logic [15:0] seq, input logic [15:0] id, input logic [63:0] tai);
		@(posedge MCLK);
		RX_START <= 1'b1;
		for (int i = 0; i < n; i++) begin
			@(posedge MCLK);
			RX_START <= 1'b0;
			RX_BYTE_VALID <= 1'b1;
			RX_BYTE <= base + i[7:0];
			RX_END <= (i == n - 1);
			RX_APPLICATION_SELECTOR <= (i == n - 1) ? sel : ~sel;
			RX_UPDATE_SEQUENCE <= (i == n - 1) ? seq : ~seq;
			RX_UPDATE_TIME_TAI <= (i == n - 1) ? tai : ~tai;
			RX_SENDER_NODE_ID <= (i == n - 1) ? id : ~id;
		end
		@(posedge MCLK);
		RX_BYTE_VALID <= 1'b0;
		RX_END <= 1'b0;
		RX_BYTE <= ~RX_BYTE;
		RX_APPLICATION_SELECTOR <= ~RX_APPLICATION_SELECTOR;
		RX_UPDATE_SEQUENCE <= ~RX_UPDATE_SEQUENCE;
		RX_UPDATE_TIME_TAI <= ~RX_UPDATE_TIME_TAI;
		RX_SENDER_NODE_ID <= ~RX_SENDER_NODE_ID;
	endtask : send_frame
endmodule : far_side_model
`default_nettype wire

// >>> app_data_port_test.sv
`timescale 1ns/1ns
`default_nettype none
module app_data_port_test;
	import app_port_pkg::*;
	logic MCLK = 1'b0, RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
	logic [31:0] PADDR = 32'h0, PWDATA = 32'h0, PRDATA;
	logic PREADY, PSLVERR, SRC_PAYLOAD_VALID = 1'b0, TX_START, TX_BYTE_VALID, TX_BYTE_READY;
	logic [7:0] SRC_APPLICATION_SELECTOR = 8'h0, SRC_PAYLOAD_LENGTH = 8'h20, TX_BYTE;
	logic [255:0] SRC_PAYLOAD_BYTES = 256'h0, SNK_PAYLOAD_BYTES;
	logic [15:0] SRC_UPDATE_SEQUENCE = 16'h0, TX_UPDATE_SEQUENCE, RX_UPDATE_SEQUENCE;
	logic [63:0] SRC_UPDATE_TIME_TAI = 64'h0, TX_UPDATE_TIME_TAI, RX_UPDATE_TIME_TAI;
	logic [7:0] TX_APPLICATION_SELECTOR, RX_APPLICATION_SELECTOR, SNK_APPLICATION_SELECTOR;
	logic RX_START, RX_BYTE_VALID, RX_END, SNK_PAYLOAD_VALID;
	logic [7:0] RX_BYTE, SNK_PAYLOAD_LENGTH;
	logic [15:0] RX_SENDER_NODE_ID, SNK_UPDATE_SEQUENCE, SNK_SENDER_NODE_ID;
	logic [63:0] SNK_UPDATE_TIME_TAI;
	int error_cnt = 0, checked = 0, start_cnt = 0, snk_cnt = 0;

	always #2 MCLK = ~MCLK;
	always @(posedge MCLK) begin
		start_cnt += (TX_START === 1'b1);
		snk_cnt += (SNK_PAYLOAD_VALID === 1'b1);
	end

	app_data_port app_data_port_inst (.MCLK(MCLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
		.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
		.PSLVERR(PSLVERR), .SRC_APPLICATION_SELECTOR(SRC_APPLICATION_SELECTOR),
		.SRC_PAYLOAD_BYTES(SRC_PAYLOAD_BYTES), .SRC_PAYLOAD_LENGTH(SRC_PAYLOAD_LENGTH),
		.SRC_PAYLOAD_VALID(SRC_PAYLOAD_VALID), .SRC_UPDATE_SEQUENCE(SRC_UPDATE_SEQUENCE),
		.SRC_UPDATE_TIME_TAI(SRC_UPDATE_TIME_TAI), .TX_START(TX_START),
		.TX_BYTE_VALID(TX_BYTE_VALID), .TX_BYTE(TX_BYTE), .TX_BYTE_READY(TX_BYTE_READY),
		.TX_APPLICATION_SELECTOR(TX_APPLICATION_SELECTOR), .TX_UPDATE_SEQUENCE(TX_UPDATE_SEQUENCE),
		.TX_UPDATE_TIME_TAI(TX_UPDATE_TIME_TAI), .RX_START(RX_START), .RX_BYTE_VALID(RX_BYTE_VALID),
		.RX_BYTE(RX_BYTE), .RX_END(RX_END), .RX_APPLICATION_SELECTOR(RX_APPLICATION_SELECTOR),
		.RX_UPDATE_SEQUENCE(RX_UPDATE_SEQUENCE), .RX_UPDATE_TIME_TAI(RX_UPDATE_TIME_TAI),
		.RX_SENDER_NODE_ID(RX_SENDER_NODE_ID), .SNK_APPLICATION_SELECTOR(SNK_APPLICATION_SELECTOR),
		.SNK_PAYLOAD_BYTES(SNK_PAYLOAD_BYTES), .SNK_PAYLOAD_LENGTH(SNK_PAYLOAD_LENGTH),
		.SNK_PAYLOAD_VALID(SNK_PAYLOAD_VALID), .SNK_UPDATE_SEQUENCE(SNK_UPDATE_SEQUENCE),
		.SNK_UPDATE_TIME_TAI(SNK_UPDATE_TIME_TAI), .SNK_SENDER_NODE_ID(SNK_SENDER_NODE_ID));

	far_side_model far_side_model_inst (.MCLK(MCLK), .TX_BYTE_VALID(TX_BYTE_VALID),
		.TX_BYTE(TX_BYTE), .TX_BYTE_READY(TX_BYTE_READY), .RX_START(RX_START),
		.RX_BYTE_VALID(RX_BYTE_VALID), .RX_BYTE(RX_BYTE), .RX_END(RX_END),
		.RX_APPLICATION_SELECTOR(RX_APPLICATION_SELECTOR), .RX_UPDATE_SEQUENCE(RX_UPDATE_SEQUENCE),
		.RX_UPDATE_TIME_TAI(RX_UPDATE_TIME_TAI), .RX_SENDER_NODE_ID(RX_SENDER_NODE_ID));

	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		checked++;
		if (seen !== exp) begin
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
			error_cnt++;
		end
	endtask : chk

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_of_test

	task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge MCLK);
		PSEL <= 1'b1;
		PWRITE <= wr;
		PADDR <= a;
		PWDATA <= d;
		@(posedge MCLK);
		PENABLE <= 1'b1;
		do begin
			@(posedge MCLK);
		end while (PREADY !== 1'b1);
		q = PRDATA;
		e = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask : apb

	////////////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		logic [31:0] q;
		logic e;
		apb(1'b0, OFS_CTRL, 32'h0, q, e);
		chk(q[CTRL_ROUTE_BIT], CTRL_RESET);
		apb(1'b0, 32'h0000_0010, 32'h0, q, e);
		chk({e, q}, 64'h1_0000_0000);
		@(posedge MCLK);
		SRC_PAYLOAD_VALID <= 1'b1;
		@(posedge MCLK);
		SRC_PAYLOAD_VALID <= 1'b0;
		far_side_model_inst.send_frame(4, 8'h00, 8'h01, 16'h1, 16'h1, 64'h1);
		repeat (10) @(posedge MCLK);
		chk(start_cnt + snk_cnt, 64'h0);
		apb(1'b1, OFS_CTRL, 32'h1, q, e);
		@(posedge MCLK);
		apb(1'b0, OFS_STATUS, 32'h0, q, e);
		chk(q[STAT_ROUTE_BIT], 1'b1);
	endtask : t_regs

	// Source bytes, selector and time are scrambled right after capture; the frame must keep the old record
	task automatic t_send();
		int n;
		logic [31:0] q;
		logic e;
		n = 0;
		far_side_model_inst.stall = 1'b1;
		for (int i = 0; i < 32; i++)
			SRC_PAYLOAD_BYTES[8*i+:8] <= 8'h10 + i[7:0];
		SRC_APPLICATION_SELECTOR <= 8'h5A;
		SRC_UPDATE_SEQUENCE <= SRC_UPDATE_SEQUENCE + 16'h1;
		SRC_UPDATE_TIME_TAI <= 64'h0123_4567_89AB_CDEF;
		SRC_PAYLOAD_LENGTH <= PAYLOAD_LEN_FULL;
		SRC_PAYLOAD_VALID <= 1'b1;
		@(posedge MCLK);
		SRC_PAYLOAD_VALID <= 1'b0;
		SRC_PAYLOAD_BYTES <= '1;
		SRC_APPLICATION_SELECTOR <= 8'h00;
		SRC_UPDATE_TIME_TAI <= 64'h0;
		apb(1'b0, OFS_STATUS, 32'h0, q, e);
		chk({q[STAT_PEND_BIT], q[STAT_ROUTE_BIT]}, 2'h3);
		while (far_side_model_inst.got.size() < 32 && n < 300) begin
			@(posedge MCLK);
			n++;
		end
		repeat (3) @(posedge MCLK);
		chk(far_side_model_inst.got.size(), 64'h20);
		for (int i = 0; i < 32; i++)
			chk(far_side_model_inst.got[i], 8'h10 + i[7:0]);
		chk(TX_APPLICATION_SELECTOR, 8'h5A);
		chk(TX_UPDATE_SEQUENCE, 16'h1);
		chk(TX_UPDATE_TIME_TAI, 64'h0123_4567_89AB_CDEF);
		chk({start_cnt[7:0], TX_BYTE_VALID}, 9'h2);
		apb(1'b0, OFS_TX_CNT, 32'h0, q, e);
		chk(q, 32'h0000_0001);
	endtask : t_send

	task automatic t_frame(input int n, input logic [15:0] id, input int exp);
		int c;
		logic [31:0] q0;
		logic [31:0] q;
		logic e;
		c = snk_cnt;
		apb(1'b0, OFS_RX_CNT, 32'h0, q0, e);
		far_side_model_inst.send_frame(n, 8'h30, 8'hC3, 16'hBEEF, id, 64'hFEDC_BA98_7654_3210);
		repeat (4) @(posedge MCLK);
		chk(snk_cnt - c, exp);
		if (exp == 1) begin
			chk(SNK_PAYLOAD_LENGTH, n);
			for (int i = 0; i < n; i++)
				chk(SNK_PAYLOAD_BYTES[8*i+:8], 8'h30 + i[7:0]);
			chk(SNK_APPLICATION_SELECTOR, 8'hC3);
			chk(SNK_UPDATE_SEQUENCE, 16'hBEEF);
			chk(SNK_UPDATE_TIME_TAI, 64'hFEDC_BA98_7654_3210);
			chk(SNK_SENDER_NODE_ID, id);
		end
		apb(1'b0, OFS_RX_CNT, 32'h0, q, e);
		chk(q - q0, exp);
	endtask : t_frame

	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge MCLK);
		RST <= 1'b0;
		@(posedge MCLK);
		t_regs();
		t_send();
		t_frame(32, 16'h00FF, 1);
		t_frame(5, 16'h0007, 1);
		t_frame(32, 16'h0100, 0);
		end_of_test();
	end

	// Whole run needs well under 2000 cycles
	initial begin
		#40000;
		error_cnt++;
		end_of_test();
	end
endmodule : app_data_port_test
`default_nettype wire
